// *** pcscr_regs.vh ***
// Offsets, field positions, reset values for status/class registers
`ifndef PCSCR_REGS_VH
`define PCSCR_REGS_VH

`define PCSCR_CMD_OFF          8'h04
`define PCSCR_STATUS_OFF       8'h06
`define PCSCR_CLASS_OFF        8'h08

`define PCSCR_CMD_PAR_RESP_BIT 6
`define PCSCR_CMD_SYSERR_BIT   8
`define PCSCR_CMD_INTDIS_BIT   10
`define PCSCR_CMD_RESET        16'h0000

`define PCSCR_ST_PARITY_BIT    15
`define PCSCR_ST_SYSERR_BIT    14
`define PCSCR_ST_RECEIVED_MASTER_ABORT_FLAG_BIT    13
`define PCSCR_ST_TABORT_R_BIT  12
`define PCSCR_ST_TABORT_S_BIT  11
`define PCSCR_ST_MASTER_DATA_PARITY_FLAG_BIT   8
`define PCSCR_ST_INT_BIT       3
`define PCSCR_ST_DEVSEL_MEDIUM 2'b01
`define PCSCR_ST_DEVSEL_LSB    9
`define PCSCR_ST_CAPABILITIES_PRESENT_BIT   4
`define PCSCR_ST_RESET         16'h0210

`define PCSCR_BASE_CLASS       8'h0c
`define PCSCR_SUB_CLASS        8'h00
`define PCSCR_PROG_MODEL       8'h10

`endif

// *** pcscr_rcu_flag.v ***
// One sticky error flag, set by hardware, cleared by writing one
`timescale 1ns/1ps
module pcscr_rcu_flag (
  input  wire core_clk,
  input  wire rst_n,
  input  wire clk_en,
  input  wire set_evt,
  input  wire clr_req,
  output reg  flag_q
);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (clk_en) begin
      if (set_evt) begin
        flag_q <= 1'b1;
      end else if (clr_req) begin
        flag_q <= 1'b0;
      end
    end
  end

endmodule // pcscr_rcu_flag

// *** pcscr_cfg.v ***
// Config status word, class word, and interrupt pin gate
`timescale 1ns/1ps
`include "pcscr_regs.vh"
module pcscr_cfg #(
  parameter [7:0] REVISION = 8'h5a // Arbitrary revision value
) (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        clk_en,
  input  wire        cfg_rd,
  input  wire        cfg_wr,
  input  wire [7:0]  cfg_addr,
  input  wire [3:0]  cfg_be,
  input  wire [31:0] cfg_wdata,
  output reg  [31:0] cfg_rdata_q,
  output reg         cfg_ack_q,
  input  wire        addr_parity_err,
  input  wire        data_parity_err,
  input  wire        perr_seen,
  input  wire        master_phase,
  input  wire        master_abort_evt,
  input  wire        target_abort_rcv_evt,
  input  wire        target_abort_sig_evt,
  input  wire        func_int_pending,
  output reg         perr_drive_q,
  output reg         serr_drive_q,
  output reg         int_active_q
);

  ////////////////////////////////////////////////////////////////////////
  // Command word (writable enable and interrupt-disable bits only)
  localparam [7:0] CMD_DW   = `PCSCR_CMD_OFF >> 2;
  localparam [7:0] CLASS_DW = `PCSCR_CLASS_OFF >> 2;
  reg  [15:0] cmd_q;
  wire        par_resp_en = cmd_q[`PCSCR_CMD_PAR_RESP_BIT];
  wire        syserr_en   = cmd_q[`PCSCR_CMD_SYSERR_BIT];
  wire        int_dis     = cmd_q[`PCSCR_CMD_INTDIS_BIT];
  wire        dword0_hit  = ({2'b00, cfg_addr[7:2]} == CMD_DW);
  wire        cmd_wr      = cfg_wr && dword0_hit;
  // Status word occupies upper half of the same dword
  wire        st_wr       = cmd_wr && cfg_be[3];

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= `PCSCR_CMD_RESET;
    end else if (clk_en && cmd_wr) begin
      if (cfg_be[0]) begin
        cmd_q[`PCSCR_CMD_PAR_RESP_BIT] <= cfg_wdata[`PCSCR_CMD_PAR_RESP_BIT];
      end
      if (cfg_be[1]) begin
        cmd_q[`PCSCR_CMD_SYSERR_BIT] <= cfg_wdata[`PCSCR_CMD_SYSERR_BIT];
        cmd_q[`PCSCR_CMD_INTDIS_BIT] <= cfg_wdata[`PCSCR_CMD_INTDIS_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error drivers and sticky flags
  wire serr_evt = syserr_en && addr_parity_err;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      perr_drive_q <= 1'b0;
      serr_drive_q <= 1'b0;
    end else if (clk_en) begin
      perr_drive_q <= par_resp_en && data_parity_err;
      serr_drive_q <= serr_evt;
    end
  end

  wire [5:0] flag_set;
  wire [5:0] flag_q;
  assign flag_set[5] = addr_parity_err || data_parity_err;
  assign flag_set[4] = serr_drive_q;
  assign flag_set[3] = master_abort_evt;
  assign flag_set[2] = target_abort_rcv_evt;
  assign flag_set[1] = target_abort_sig_evt;
  assign flag_set[0] = perr_seen && master_phase && par_resp_en;

  // Write-one clear positions, in the high half of the dword
  localparam [95:0] FLAG_POS = {16'd`PCSCR_ST_PARITY_BIT, 16'd`PCSCR_ST_SYSERR_BIT,
                                16'd`PCSCR_ST_RECEIVED_MASTER_ABORT_FLAG_BIT, 16'd`PCSCR_ST_TABORT_R_BIT,
                                16'd`PCSCR_ST_TABORT_S_BIT, 16'd`PCSCR_ST_MASTER_DATA_PARITY_FLAG_BIT};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
      pcscr_rcu_flag u_flag (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .set_evt  (flag_set[gi]),
        .clr_req  (st_wr && cfg_wdata[16 + FLAG_POS[gi*16 +: 4]]),
        .flag_q   (flag_q[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status and pin
  reg int_status_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_status_q <= 1'b0;
      int_active_q <= 1'b0;
    end else if (clk_en) begin
      int_status_q <= func_int_pending;
      int_active_q <= func_int_pending && !int_dis;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data
  reg [15:0] status_word;
  always @* begin
    status_word = 16'h0000;
    status_word[`PCSCR_ST_PARITY_BIT]   = flag_q[5];
    status_word[`PCSCR_ST_SYSERR_BIT]   = flag_q[4];
    status_word[`PCSCR_ST_RECEIVED_MASTER_ABORT_FLAG_BIT]   = flag_q[3];
    status_word[`PCSCR_ST_TABORT_R_BIT] = flag_q[2];
    status_word[`PCSCR_ST_TABORT_S_BIT] = flag_q[1];
    status_word[`PCSCR_ST_MASTER_DATA_PARITY_FLAG_BIT]  = flag_q[0];
    status_word[`PCSCR_ST_DEVSEL_LSB +: 2] = `PCSCR_ST_DEVSEL_MEDIUM;
    status_word[`PCSCR_ST_CAPABILITIES_PRESENT_BIT]  = 1'b1;
    status_word[`PCSCR_ST_INT_BIT]      = int_status_q;
  end

  wire [31:0] class_word = {`PCSCR_BASE_CLASS, `PCSCR_SUB_CLASS,
                            `PCSCR_PROG_MODEL, REVISION};

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_q <= 32'h00000000;
      cfg_ack_q   <= 1'b0;
    end else if (clk_en) begin
      cfg_ack_q <= cfg_rd || cfg_wr;
      if (cfg_rd && dword0_hit) begin
        cfg_rdata_q <= {status_word, cmd_q};
      end else if (cfg_rd && {2'b00, cfg_addr[7:2]} == CLASS_DW) begin
        cfg_rdata_q <= class_word;
      end else if (cfg_rd) begin
        cfg_rdata_q <= 32'h00000000;
      end
    end
  end

endmodule // pcscr_cfg

// *** pcscr_cfg_properties.sv ***
// Port checks for status and class registers
`timescale 1ns/1ps
module pcscr_cfg_chk (
  input wire        core_clk,
  input wire        rst_n,
  input wire        clk_en,
  input wire        cfg_rd,
  input wire        cfg_wr,
  input wire [7:0]  cfg_addr,
  input wire [31:0] cfg_rdata_q,
  input wire        cfg_ack_q,
  input wire        addr_parity_err,
  input wire        data_parity_err,
  input wire        func_int_pending,
  input wire        perr_drive_q,
  input wire        serr_drive_q,
  input wire        int_active_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ack_follow_a: assert property ((cfg_rd || cfg_wr) && clk_en |=> cfg_ack_q)
    else $error("no ack after request");
  ack_cause_a: assert property (cfg_ack_q |-> $past((cfg_rd || cfg_wr) && clk_en))
    else $error("ack without request");
  rdata_hold_a: assert property (!$past(cfg_rd && clk_en) |-> $stable(cfg_rdata_q))
    else $error("read data moved");
  status_fixed_a: assert property ($past(cfg_rd && clk_en && cfg_addr[7:2] == 6'h01) |->
    (cfg_rdata_q[26:16] & 11'h6f7) == 11'h210) else $error("status fixed bits wrong");
  class_fixed_a: assert property ($past(cfg_rd && clk_en && cfg_addr[7:2] == 6'h02) |->
    cfg_rdata_q[31:8] == 24'h0c0010) else $error("class bytes wrong");
  perr_gate_a: assert property (perr_drive_q |-> $past(data_parity_err))
    else $error("parity driver without error");
  serr_gate_a: assert property (serr_drive_q |-> $past(addr_parity_err))
    else $error("system error driver without cause");
  int_gate_a: assert property (int_active_q |-> $past(func_int_pending))
    else $error("interrupt pin without pending");
endmodule // pcscr_cfg_chk
bind pcscr_cfg pcscr_cfg_chk chk (.*);

// *** pcscr_host.sv ***
// Host bridge model issuing configuration cycles
`timescale 1ns/1ps
module pcscr_host (
  input  wire        core_clk,
  output reg         cfg_rd,
  output reg         cfg_wr,
  output reg  [7:0]  cfg_addr,
  output reg  [3:0]  cfg_be,
  output reg  [31:0] cfg_wdata
);
  initial {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = 45'h0;
  // One-cycle request; address and data inverted once released
  task xfer(input bit w, input [7:0] a, input [3:0] be, input [31:0] d);
    @(posedge core_clk);
    {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {!w, w, a, be, d};
    @(posedge core_clk);
    {cfg_rd, cfg_wr, cfg_addr, cfg_wdata} <= {2'b00, ~a, ~d};
  endtask
endmodule // pcscr_host

// *** testbench.sv ***
// Self-checking bench for status and class registers
`timescale 1ns/1ps
module testbench;
  localparam [7:0] REV = 8'h3c; // Arbitrary revision value
  reg core_clk = 0, rst_n = 0, pend = 0, rd_d = 0;
  reg [6:0] ev = 0;
  wire cfg_rd, cfg_wr, cfg_ack_q, perr_drive_q, serr_drive_q, int_active_q;
  wire [7:0] cfg_addr;
  wire [3:0] cfg_be;
  wire [31:0] cfg_wdata, cfg_rdata_q;
  logic [31:0] exp_q[$];
  int mismatches = 0, cmp_count = 0;
  bit [6:0] evt[6] = '{7'h40, 7'h20, 7'h04, 7'h02, 7'h01, 7'h18};
  bit [15:0] stt[6] = '{16'h8210, 16'h8210, 16'h2210, 16'h1210, 16'h0a10, 16'h0210};
  pcscr_host host (.core_clk(core_clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
  pcscr_cfg #(.REVISION(REV)) uut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
    .cfg_ack_q(cfg_ack_q), .addr_parity_err(ev[6]), .data_parity_err(ev[5]), .perr_seen(ev[4]),
    .master_phase(ev[3]), .master_abort_evt(ev[2]), .target_abort_rcv_evt(ev[1]),
    .target_abort_sig_evt(ev[0]), .func_int_pending(pend), .perr_drive_q(perr_drive_q),
    .serr_drive_q(serr_drive_q), .int_active_q(int_active_q));
  initial forever #10 core_clk = ~core_clk;
  task check(input string n, input [31:0] seen, input [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, want, seen);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    exp_q.push_back(e);
    host.xfer(0, a, 4'hf, 0);
  endtask
  task pulse(input [6:0] v);
    @(posedge core_clk);
    ev <= v;
    @(posedge core_clk);
    ev <= 0;
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Scoreboard: read answers against oldest note
  always @(posedge core_clk) begin
    if (cfg_ack_q === 1'b1 && rd_d) check("read data", cfg_rdata_q, exp_q.pop_front());
    rd_d <= cfg_rd;
  end
  initial begin
    #1000000;
    mismatches++;
    end_sim();
  end
  initial begin
    int i, p;
    bit [15:0] cmd;
    cmd = $urandom(82);
    repeat (12) @(posedge core_clk);
    rst_n <= 1;
    rd(8'h06, 32'h0210_0000);
    host.xfer(1, 8'h08, 4'hf, $urandom);
    rd(8'h08, {24'h0c0010, REV});
    rd(8'h40, 0);
    $display("test constants done");
    for (p = 0; p < 2; p++) begin
      cmd = p ? 16'h0140 : 16'h0;
      host.xfer(1, 8'h04, 4'h3, {16'h0, cmd});
      for (i = 0; i < 6; i++) begin
        pulse(evt[i]);
        host.xfer(1, 8'h04, 4'h8, 0);
        rd(8'h04, {stt[i] | ((p && i == 0) ? 16'h4000 : 0) | ((p && i == 5) ? 16'h0100 : 0), cmd});
        host.xfer(1, 8'h04, 4'h8, 32'hff00_0000);
        rd(8'h04, {16'h0210, cmd});
      end
    end
    $display("test events done");
    pend <= 1;
    repeat (3) @(posedge core_clk);
    rd(8'h04, {16'h0218, 16'h0140});
    check("interrupt pin", {31'h0, int_active_q}, 1);
    host.xfer(1, 8'h04, 4'h2, 32'h0500);
    rd(8'h04, {16'h0218, 16'h0540});
    check("interrupt pin", {31'h0, int_active_q}, 0);
    $display("test interrupt done");
    for (i = 0; i < 9 && exp_q.size() > 0; i++) @(posedge core_clk);
    if (exp_q.size() > 0) mismatches++;
    end_sim();
  end
endmodule // testbench
